//--- rtl/lcd_cfg_params.svh
// Purpose: Offsets, field positions, reset values and counts for the LCD clock/blink block
// Assumes: Byte-wide register port, 100 MHz bus clock
// Notes: Most numbers of the block live here once; the divide field, status bits and checks are coded in the RTL
`ifndef LCD_CFG_PARAMS_SVH
`define LCD_CFG_PARAMS_SVH

`define LCD_SEG_BYTES 21
`define LCD_SEG_COUNT 164
`define LCD_OFS_CMD 8'h20
`define LCD_OFS_CLKS 8'h21
`define LCD_OFS_SUPPLY 8'h22
`define LCD_OFS_BCTL 8'h23
`define LCD_OFS_STATUS 8'h24

`define LCD_BANK_SEL_BIT 3
`define LCD_CLK_SRC_BIT 7
`define LCD_PRESCALE_BIT 6
`define LCD_PUMP_EN_BIT 7
`define LCD_PUMP_MODE_BIT 6
`define LCD_PUMP_ADJ_LSB 4
`define LCD_STRONG_BUF_BIT 3
`define LCD_BUF_BYPASS_BIT 2
`define LCD_SUPPLY_SEL_LSB 0
`define LCD_BLINK_CMD_BIT 7
`define LCD_BLINK_SCOPE_BIT 3
`define LCD_BLINK_RATE_LSB 0

`define LCD_CLKS_RESET 8'h00
`define LCD_SUPPLY_RESET 8'h00
`define LCD_BCTL_RESET 8'h00

`define LCD_PRESCALE_DIV 16
`define LCD_PUMP_DIV 6
`define LCD_BLINK_EXP 5

`endif

//--- rtl/lcd_cfg_pkg.sv
// Purpose: Types shared by the LCD clock/blink block
// Assumes: Constants come from lcd_cfg_params.svh
// Notes: Carrier structs and the blink state enum only
package lcd_cfg_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_type;

   typedef struct packed {
      logic pump_enable;
      logic internal_bias;
      logic pump_tripler;
      logic strong_buffer;
      logic buffer_bypass;
      logic [1:0] supply_select;
   } supply_ctrl_type;

   typedef enum logic [2:0] {
      BLINK_IDLE = 3'b001,
      BLINK_ON = 3'b010,
      BLINK_OFF = 3'b100
   } blink_state_type;

endpackage

//--- rtl/segment_memory.sv
// Purpose: Two banks of segment bits, on/off and blink-enable
// Assumes: One write port, bank chosen by the caller
// Notes: Bits above the last segment are held at zero
`include "lcd_cfg_params.svh"
module segment_memory #(
   parameter int SEG_BYTES = `LCD_SEG_BYTES,
   parameter int SEG_COUNT = `LCD_SEG_COUNT
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic i_bank,
   input wire logic [$clog2(SEG_BYTES)-1:0] i_index,
   input wire logic [7:0] i_wdata,
   output logic [8*SEG_BYTES-1:0] o_on_bits,
   output logic [8*SEG_BYTES-1:0] o_blink_bits
);
   localparam int LAST_BITS = SEG_COUNT - 8 * (SEG_BYTES - 1);
   localparam logic [7:0] LAST_MASK = 8'((16'h0001 << LAST_BITS) - 16'h0001);

   logic [8*SEG_BYTES-1:0] on_q, on_d, blink_q, blink_d;
   logic [7:0] wmasked;

   always_comb begin
      on_d = on_q;
      blink_d = blink_q;
      wmasked = (32'(i_index) == SEG_BYTES - 1) ? (i_wdata & LAST_MASK) : i_wdata;
      if (i_wr_en) begin
         if (i_bank) begin
            blink_d[8*i_index +: 8] = wmasked;
         end else begin
            on_d[8*i_index +: 8] = wmasked;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         on_q <= '0;
         blink_q <= '0;
      end else begin
         on_q <= on_d;
         blink_q <= blink_d;
      end
   end

   assign o_on_bits = on_q;
   assign o_blink_bits = blink_q;
endmodule

//--- rtl/lcd_clock_supply_blink.sv
// Purpose: LCD base clock, charge pump controls, segment banks and blinking
// Assumes: i_frame_start is a one-cycle pulse from the waveform generator on i_clk
// Notes: The external reference is a pin and is synchronised; bus clock source ticks every cycle
`include "lcd_cfg_params.svh"

module lcd_clock_supply_blink #(
   parameter int SEG_BYTES = `LCD_SEG_BYTES,
   parameter int SEG_COUNT = `LCD_SEG_COUNT
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input lcd_cfg_pkg::bus_req_type i_bus,
   input wire logic i_ext_ref_clk,
   input wire logic i_frame_start,
   output logic [7:0] o_rdata,
   output logic [8*SEG_BYTES-1:0] o_segment_on,
   output logic o_segment_base_tick,
   output logic o_pump_clk,
   output lcd_cfg_pkg::supply_ctrl_type o_supply,
   output logic o_blink_off_phase
);
   localparam int IW = $clog2(SEG_BYTES);
   localparam int SB = 8 * SEG_BYTES;

   // Register file
   logic bank_q, bank_d;
   logic [7:0] clks_q, clks_d, supply_q, supply_d, bctl_q, bctl_d, rdata_q, rdata_d;
   logic seg_sel, seg_wr;
   logic [IW-1:0] seg_idx;
   logic [SB-1:0] on_bits, blink_bits;
   lcd_cfg_pkg::blink_state_type state_q, state_d;

   assign seg_sel = 32'(i_bus.addr) < SEG_BYTES;
   assign seg_idx = i_bus.addr[IW-1:0];
   assign seg_wr = i_bus.wr && seg_sel;

   segment_memory #(.SEG_BYTES(SEG_BYTES), .SEG_COUNT(SEG_COUNT)) u_mem (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_wr_en(seg_wr),
      .i_bank(bank_q),
      .i_index(seg_idx),
      .i_wdata(i_bus.wdata),
      .o_on_bits(on_bits),
      .o_blink_bits(blink_bits)
   );

   always_comb begin
      bank_d = bank_q;
      clks_d = clks_q;
      supply_d = supply_q;
      bctl_d = bctl_q;
      rdata_d = 8'h00;
      if (i_bus.wr) begin
         case (i_bus.addr)
            `LCD_OFS_CMD: bank_d = i_bus.wdata[`LCD_BANK_SEL_BIT];
            `LCD_OFS_CLKS: clks_d = i_bus.wdata;
            `LCD_OFS_SUPPLY: supply_d = i_bus.wdata;
            `LCD_OFS_BCTL: bctl_d = i_bus.wdata;
            default: ;
         endcase
      end
      if (i_bus.rd) begin
         if (seg_sel) begin
            // Bank select decides which flags a read returns
            rdata_d = bank_q ? blink_bits[8*seg_idx +: 8] : on_bits[8*seg_idx +: 8];
         end else begin
            case (i_bus.addr)
               `LCD_OFS_CMD: rdata_d = 8'(bank_q) << `LCD_BANK_SEL_BIT;
               `LCD_OFS_CLKS: rdata_d = clks_q;
               `LCD_OFS_SUPPLY: rdata_d = supply_q;
               `LCD_OFS_BCTL: rdata_d = bctl_q;
               `LCD_OFS_STATUS: rdata_d = {6'h00, state_q == lcd_cfg_pkg::BLINK_OFF,
                                           state_q != lcd_cfg_pkg::BLINK_IDLE};
               default: rdata_d = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bank_q <= 1'b0;
         clks_q <= `LCD_CLKS_RESET;
         supply_q <= `LCD_SUPPLY_RESET;
         bctl_q <= `LCD_BCTL_RESET;
         rdata_q <= 8'h00;
      end else begin
         bank_q <= bank_d;
         clks_q <= clks_d;
         supply_q <= supply_d;
         bctl_q <= bctl_d;
         rdata_q <= rdata_d;
      end
   end

   // Clock chain: source, prescaler, divider, pump clock
   logic [2:0] ref_sync_q, ref_sync_d;
   logic ref_lvl_q, ref_lvl_d, ref_rise, src_tick, pre_tick;
   logic [3:0] pre_cnt_q, pre_cnt_d;
   logic [5:0] div_cnt_q, div_cnt_d, div_field, pump_cnt_q, pump_cnt_d, pump_half;
   logic base_q, base_d, pump_q, pump_d;
   logic [1:0] pump_adj;

   assign div_field = clks_q[5:0];
   assign pump_adj = supply_q[`LCD_PUMP_ADJ_LSB +: 2];
   assign ref_rise = ref_sync_q[1] && ref_sync_q[2] && !ref_lvl_q;
   assign src_tick = clks_q[`LCD_CLK_SRC_BIT] ? 1'b1 : ref_rise;
   assign pre_tick = src_tick && (!clks_q[`LCD_PRESCALE_BIT] ||
                                  pre_cnt_q == 4'(`LCD_PRESCALE_DIV - 1));
   // Half pump period in base ticks: 3 * 2^(field+1)
   assign pump_half = 6'((`LCD_PUMP_DIV / 2) << ({1'b0, pump_adj} + 3'd1));

   always_comb begin
      ref_sync_d = {ref_sync_q[1:0], i_ext_ref_clk};
      ref_lvl_d = (ref_sync_q[1] == ref_sync_q[2]) ? ref_sync_q[2] : ref_lvl_q;
      pre_cnt_d = pre_cnt_q;
      if (src_tick) begin
         pre_cnt_d = (pre_cnt_q == 4'(`LCD_PRESCALE_DIV - 1)) ? 4'h0 : pre_cnt_q + 4'h1;
      end
      div_cnt_d = div_cnt_q;
      base_d = 1'b0;
      if (pre_tick) begin
         // A shrunk field is caught by the compare so the count never runs away
         if (div_cnt_q >= div_field) begin
            div_cnt_d = 6'h00;
            base_d = 1'b1;
         end else begin
            div_cnt_d = div_cnt_q + 6'h01;
         end
      end
      pump_cnt_d = pump_cnt_q;
      pump_d = pump_q;
      if (!supply_q[`LCD_PUMP_EN_BIT]) begin
         pump_cnt_d = 6'h00;
         pump_d = 1'b0;
      end else if (base_q) begin
         if (pump_cnt_q >= pump_half - 6'h01) begin
            pump_cnt_d = 6'h00;
            pump_d = !pump_q;
         end else begin
            pump_cnt_d = pump_cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ref_sync_q <= 3'h0;
         ref_lvl_q <= 1'b0;
         pre_cnt_q <= 4'h0;
         div_cnt_q <= 6'h00;
         base_q <= 1'b0;
         pump_cnt_q <= 6'h00;
         pump_q <= 1'b0;
      end else begin
         ref_sync_q <= ref_sync_d;
         ref_lvl_q <= ref_lvl_d;
         pre_cnt_q <= pre_cnt_d;
         div_cnt_q <= div_cnt_d;
         base_q <= base_d;
         pump_cnt_q <= pump_cnt_d;
         pump_q <= pump_d;
      end
   end

   // Blink sequencer
   logic [10:0] blink_cnt_q, blink_cnt_d, half_last;
   logic [2:0] rate_q, rate_d;
   logic scope_q, scope_d;
   logic [SB-1:0] seg_d, seg_q;
   lcd_cfg_pkg::supply_ctrl_type supply_d_s, supply_s_q;

   assign half_last = 11'((12'h0001 << (`LCD_BLINK_EXP - 1 + rate_q)) - 12'h0001);

   always_comb begin
      state_d = state_q;
      blink_cnt_d = blink_cnt_q;
      rate_d = rate_q;
      scope_d = scope_q;
      if (i_frame_start) begin
         rate_d = bctl_q[`LCD_BLINK_RATE_LSB +: 3];
         scope_d = bctl_q[`LCD_BLINK_SCOPE_BIT];
         if (!bctl_q[`LCD_BLINK_CMD_BIT]) begin
            state_d = lcd_cfg_pkg::BLINK_IDLE;
         end else if (state_q == lcd_cfg_pkg::BLINK_IDLE) begin
            state_d = lcd_cfg_pkg::BLINK_ON;
            blink_cnt_d = 11'h000;
         end
      end
      if (state_q != lcd_cfg_pkg::BLINK_IDLE && state_d != lcd_cfg_pkg::BLINK_IDLE &&
          base_q && !(i_frame_start && state_q == lcd_cfg_pkg::BLINK_IDLE)) begin
         if (blink_cnt_q >= half_last) begin
            blink_cnt_d = 11'h000;
            unique case (state_q)
               lcd_cfg_pkg::BLINK_ON: state_d = lcd_cfg_pkg::BLINK_OFF;
               lcd_cfg_pkg::BLINK_OFF: state_d = lcd_cfg_pkg::BLINK_ON;
               lcd_cfg_pkg::BLINK_IDLE: state_d = lcd_cfg_pkg::BLINK_IDLE;
            endcase
         end else begin
            blink_cnt_d = blink_cnt_q + 11'h001;
         end
      end
      // Off half blanks either every segment or those with both flags set
      seg_d = on_bits;
      if (state_q == lcd_cfg_pkg::BLINK_OFF) begin
         seg_d = scope_q ? '0 : (on_bits & ~blink_bits);
      end
      supply_d_s.pump_enable = supply_q[`LCD_PUMP_EN_BIT];
      supply_d_s.internal_bias = supply_q[`LCD_PUMP_EN_BIT];
      supply_d_s.pump_tripler = supply_q[`LCD_PUMP_MODE_BIT];
      supply_d_s.strong_buffer = supply_q[`LCD_STRONG_BUF_BIT];
      supply_d_s.buffer_bypass = supply_q[`LCD_BUF_BYPASS_BIT];
      supply_d_s.supply_select = supply_q[`LCD_SUPPLY_SEL_LSB +: 2];
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= lcd_cfg_pkg::BLINK_IDLE;
         blink_cnt_q <= 11'h000;
         rate_q <= 3'h0;
         scope_q <= 1'b0;
         seg_q <= '0;
         supply_s_q <= '0;
      end else begin
         state_q <= state_d;
         blink_cnt_q <= blink_cnt_d;
         rate_q <= rate_d;
         scope_q <= scope_d;
         seg_q <= seg_d;
         supply_s_q <= supply_d_s;
      end
   end

   assign o_rdata = rdata_q;
   assign o_segment_on = seg_q;
   assign o_segment_base_tick = base_q;
   assign o_pump_clk = pump_q;
   assign o_supply = supply_s_q;
   assign o_blink_off_phase = state_q[2]; // One-hot bit of the off state, straight from a flop

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_bank_write;
      i_bus.wr && i_bus.addr == `LCD_OFS_CMD |=> bank_q == $past(i_bus.wdata[3]);
   endproperty
   a_bank_write: assert property (p_bank_write) else $error("bank select not stored");

   property p_blink_bank_only;
      seg_wr && bank_q |=> $stable(on_bits);
   endproperty
   a_blink_bank_only: assert property (p_blink_bank_only) else $error("on bank hit");

   property p_off_stays_off;
      1'b1 |=> (o_segment_on & ~$past(on_bits)) == '0;
   endproperty
   a_off_stays_off: assert property (p_off_stays_off) else $error("off segment lit");

   property p_bus_source;
      clks_q[7] && !clks_q[6] |-> pre_tick;
   endproperty
   a_bus_source: assert property (p_bus_source) else $error("bus clock tick lost");

   property p_prescale;
      pre_tick && clks_q[6] |-> pre_cnt_q == 4'hf && src_tick;
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler early");

   property p_divider;
      pre_tick && div_cnt_q == div_field |=> o_segment_base_tick;
   endproperty
   a_divider: assert property (p_divider) else $error("base tick missing");

   property p_pump_edge;
      $changed(o_pump_clk) && o_supply.pump_enable |-> $past(base_q);
   endproperty
   a_pump_edge: assert property (p_pump_edge) else $error("pump edge off tick");

   property p_supply_map;
      i_bus.wr && i_bus.addr == `LCD_OFS_SUPPLY |=> ##1
         o_supply.internal_bias == $past(i_bus.wdata[7], 2) &&
         o_supply.pump_tripler == $past(i_bus.wdata[6], 2) &&
         o_supply.strong_buffer == $past(i_bus.wdata[3], 2) &&
         o_supply.buffer_bypass == $past(i_bus.wdata[2], 2);
   endproperty
   a_supply_map: assert property (p_supply_map) else $error("supply bits wrong");

   property p_frame_only;
      $changed(state_q == lcd_cfg_pkg::BLINK_IDLE) |-> $past(i_frame_start);
   endproperty
   a_frame_only: assert property (p_frame_only) else $error("blink began mid frame");

   property p_no_blink;
      state_q == lcd_cfg_pkg::BLINK_IDLE |=> o_segment_on == $past(on_bits);
   endproperty
   a_no_blink: assert property (p_no_blink) else $error("blanked while idle");

   property p_phase_tick;
      $changed(o_blink_off_phase) && !$past(i_frame_start) |-> $past(base_q);
   endproperty
   a_phase_tick: assert property (p_phase_tick) else $error("phase off tick");

   c_off_phase: cover property (o_blink_off_phase && scope_q);
   c_prescaled: cover property (o_segment_base_tick && clks_q[6]);
   c_pump_toggle: cover property ($rose(o_pump_clk));
endmodule

//--- tb/glass_panel_model.sv
// Purpose: Passive model of the segment glass and charge pump load
// Assumes: Segment vector is the final lit state of each segment
// Notes: Counts lit segments and pump clocking while the pump is off
module glass_panel_model #(
   parameter int SEG_BITS = 168
) (
   input wire logic i_clk,
   input wire logic [SEG_BITS-1:0] i_segment_on,
   input wire logic i_pump_clk,
   input lcd_cfg_pkg::supply_ctrl_type i_supply,
   output logic [7:0] o_lit_count,
   output int o_pump_faults
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pump_off_q = 1'b0;
   int faults_q = 0;

   assign o_pump_faults = faults_q;

   always_comb begin
      o_lit_count = 8'h00;
      for (int i = 0; i < SEG_BITS; i++) begin
         o_lit_count = o_lit_count + 8'(i_segment_on[i]);
      end
   end

   // Settle one cycle after switch-off before judging the pump clock
   always @(posedge i_clk) begin
      pump_off_q <= !i_supply.pump_enable;
      if (pump_off_q && !i_supply.pump_enable && i_pump_clk !== 1'b0) begin
         faults_q <= faults_q + 1;
      end
   end
endmodule

//--- tb/tb_lcd_clock_supply_blink.sv
// Purpose: Self-checking bench for the LCD clock, supply and blink block
// Assumes: Bench drives frame starts and a reference at a quarter of i_clk
// Notes: Timings are measured at 1 ns after each rising edge
`include "lcd_cfg_params.svh"
module tb_lcd_clock_supply_blink;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SB = 8 * `LCD_SEG_BYTES;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   lcd_cfg_pkg::bus_req_type i_bus = '0;
   logic i_ext_ref_clk = 1'b0;
   logic i_frame_start = 1'b0;
   logic [7:0] o_rdata;
   logic [SB-1:0] o_segment_on;
   logic o_segment_base_tick;
   logic o_pump_clk;
   lcd_cfg_pkg::supply_ctrl_type o_supply;
   logic o_blink_off_phase;
   logic [7:0] lit_count;
   int pump_faults;
   int failures = 0;
   int total_checks = 0;
   logic ref_half = 1'b0;
   logic [SB-1:0] on_bits;

   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      ref_half <= ~ref_half;
      if (ref_half) begin
         i_ext_ref_clk <= ~i_ext_ref_clk;
      end
   end

   lcd_clock_supply_blink u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .i_ext_ref_clk(i_ext_ref_clk),
      .i_frame_start(i_frame_start), .o_rdata(o_rdata), .o_segment_on(o_segment_on),
      .o_segment_base_tick(o_segment_base_tick), .o_pump_clk(o_pump_clk),
      .o_supply(o_supply), .o_blink_off_phase(o_blink_off_phase));
   glass_panel_model #(.SEG_BITS(SB)) u_glass (
      .i_clk(i_clk), .i_segment_on(o_segment_on), .i_pump_clk(o_pump_clk),
      .i_supply(o_supply), .o_lit_count(lit_count), .o_pump_faults(pump_faults));

   task automatic check(input logic [SB-1:0] seen, input logic [SB-1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clk);
      i_bus <= '0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_clk);
      i_bus <= '0;
      #1;
      check(o_rdata, exp);
   endtask

   task automatic frame();
      @(posedge i_clk);
      i_frame_start <= 1'b1;
      @(posedge i_clk);
      i_frame_start <= 1'b0;
      #1;
   endtask

   function automatic logic sig(input int sel);
      case (sel)
         0: return o_segment_base_tick;
         1: return o_pump_clk;
         default: return o_blink_off_phase;
      endcase
   endfunction

   // Cycles until the chosen output reaches a level; a hang ends the run
   task automatic wait_sig(input int sel, input logic lvl, output int n);
      n = 0;
      while (sig(sel) !== lvl) begin
         @(posedge i_clk);
         #1;
         n++;
         if (n > 20000) begin
            check(1'b0, 1'b1);
            test_done();
         end
      end
   endtask

   // Second full period, so a count left from old settings is skipped
   task automatic period(input int sel, output int p);
      int a;
      int b;
      @(posedge i_clk);
      #1;
      wait_sig(sel, 1'b1, a);
      repeat (2) begin
         wait_sig(sel, 1'b0, a);
         wait_sig(sel, 1'b1, b);
      end
      p = a + b;
   endtask

   task automatic test_regs();
      rd_chk(`LCD_OFS_CLKS, `LCD_CLKS_RESET);
      rd_chk(`LCD_OFS_SUPPLY, `LCD_SUPPLY_RESET);
      rd_chk(`LCD_OFS_BCTL, `LCD_BCTL_RESET);
      rd_chk(`LCD_OFS_STATUS, 8'h00);
      wr(8'h3F, 8'hFF);
      rd_chk(8'h3F, 8'h00);
      $display("test_regs done");
   endtask

   task automatic test_supply();
      logic [7:0] vals [6] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h03, 8'hC6};
      lcd_cfg_pkg::supply_ctrl_type e;
      int p;
      foreach (vals[i]) begin
         wr(`LCD_OFS_SUPPLY, vals[i]);
         e = {vals[i][7], vals[i][7], vals[i][6], vals[i][3:2], vals[i][1:0]};
         repeat (2) @(posedge i_clk);
         #1;
         check(o_supply, e);
         rd_chk(`LCD_OFS_SUPPLY, vals[i]);
      end
      wr(`LCD_OFS_CLKS, 8'h81);
      for (int f = 0; f < 4; f++) begin
         wr(`LCD_OFS_SUPPLY, 8'h80 | 8'(f << 4));
         period(1, p);
         check(p, 2 * 6 * (2 << f));
      end
      wr(`LCD_OFS_SUPPLY, 8'h00);
      $display("test_supply done");
   endtask

   task automatic test_clock();
      logic [7:0] cfg [4] = '{8'h81, 8'h83, 8'hC1, 8'h01};
      int exp [4] = '{2, 4, 32, 8};
      int p;
      foreach (cfg[i]) begin
         wr(`LCD_OFS_CLKS, cfg[i]);
         period(0, p);
         check(p, exp[i]);
      end
      $display("test_clock done");
   endtask

   task automatic test_blink();
      int n;
      logic bad;
      logic [SB-1:0] blk;
      wr(`LCD_OFS_CLKS, 8'h81);
      wr(`LCD_OFS_CMD, 8'h00);
      wr(8'h00, 8'h0F);
      wr(8'h01, 8'h30);
      wr(8'h14, 8'hFF);
      on_bits = '0;
      on_bits[15:0] = 16'h300F;
      on_bits[163:160] = 4'hF;
      rd_chk(8'h14, 8'h0F);
      wr(`LCD_OFS_CMD, 8'hFF);
      rd_chk(`LCD_OFS_CMD, 8'h08);
      wr(8'h00, 8'h05);
      wr(8'h01, 8'h10);
      wr(8'h02, 8'h01);
      rd_chk(8'h00, 8'h05);
      wr(`LCD_OFS_CMD, 8'h00);
      rd_chk(8'h00, 8'h0F);
      check(o_segment_on, on_bits);
      blk = on_bits;
      blk[0] = 1'b0;
      blk[2] = 1'b0;
      blk[12] = 1'b0;
      wr(`LCD_OFS_BCTL, 8'h80);
      repeat (40) @(posedge i_clk);
      #1;
      check(o_blink_off_phase, 1'b0);
      frame();
      wait_sig(2, 1'b1, n);
      @(posedge i_clk);
      #1;
      check(o_segment_on, blk);
      check(lit_count, 8'd7);
      wait_sig(2, 1'b0, n);
      check(n + 1, 32);
      repeat (2) @(posedge i_clk);
      #1;
      check(o_segment_on, on_bits);
      wr(`LCD_OFS_BCTL, 8'h08);
      frame();
      repeat (3) @(posedge i_clk);
      bad = 1'b0;
      repeat (150) begin
         @(posedge i_clk);
         #1;
         bad = bad | o_blink_off_phase | (o_segment_on !== on_bits);
      end
      check(bad, 1'b0);
      for (int r = 0; r < 8; r++) begin
         wr(`LCD_OFS_BCTL, 8'h00);
         frame();
         wr(`LCD_OFS_BCTL, 8'h88 | 8'(r));
         frame();
         wait_sig(2, 1'b1, n);
         @(posedge i_clk);
         #1;
         check(o_segment_on, '0);
         rd_chk(`LCD_OFS_STATUS, 8'h03);
         // The status read above used two of the off-phase cycles
         wait_sig(2, 1'b0, n);
         check(n + 3, 2 << (4 + r));
         rd_chk(`LCD_OFS_STATUS, 8'h01);
      end
      wr(`LCD_OFS_BCTL, 8'h00);
      frame();
      $display("test_blink done");
   endtask

   initial begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      test_regs();
      test_supply();
      test_clock();
      test_blink();
      check(pump_faults, 0);
      test_done();
   end
endmodule
